/* pkg/qrw_pkg.sv */
// shared constants and types for the quad read block
package qrw_pkg;
	// command opcodes seen in the opcode phase
	localparam logic [7:0] OPC_QUAD_READ     = 8'heb;
	localparam logic [7:0] OPC_WORD_READ     = 8'he7;
	localparam logic [7:0] OPC_MODE_RESET    = 8'hff;

	// index of the last rising edge of each phase (length minus one), and dummy lengths in serial clock rising edges
	localparam logic [2:0] OPCODE_LAST       = 3'h7;
	localparam logic [2:0] ADDR_LAST         = 3'h5;
	localparam logic [2:0] MODE_LAST         = 3'h1;
	localparam logic [2:0] DUMMY_QUAD_CLKS   = 3'h4;
	localparam logic [2:0] DUMMY_WORD_CLKS   = 3'h2;

	// mode and wrap encodings and reset values
	localparam logic [1:0] MODE_SKIP_CONT    = 2'h2;
	localparam logic [7:0] MODE_BYTE_RESET   = 8'h00;
	localparam logic [2:0] WRAP_SETTING_RESET = 3'h1;
	localparam logic [5:0] WRAP_MASK_8       = 6'h07;
	localparam logic [5:0] WRAP_MASK_16      = 6'h0f;
	localparam logic [5:0] WRAP_MASK_32      = 6'h1f;
	localparam logic [5:0] WRAP_MASK_64      = 6'h3f;

	// raw serial pins as they arrive from the host
	typedef struct packed {
		logic       csN;
		logic       sclk;
		logic [3:0] io;
	} qrw_pins_s;

	// idle pin levels: chip select high, clock and data low
	localparam logic [5:0] PINS_RESET        = 6'h20;

	typedef enum logic [6:0] {
		ST_IDLE   = 7'b0000001,
		ST_OPCODE = 7'b0000010,
		ST_ADDR   = 7'b0000100,
		ST_MODE   = 7'b0001000,
		ST_DUMMY  = 7'b0010000,
		ST_DATA   = 7'b0100000,
		ST_IGNORE = 7'b1000000
	} qrw_state_e;
endpackage

/* rtl/qrw_pin_sync.sv */
// three-stage pin synchroniser with agreement filter per bit
module qrw_pin_sync #(
	parameter int                 WIDTH     = 6,
	parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
	input  wire logic             clk_sys,   // system clock
	input  wire logic             nrst,      // async reset, active low
	input  wire logic [WIDTH-1:0] pinIn,     // asynchronous pins
	output logic      [WIDTH-1:0] pinStable  // filtered level, registered
);
	// refuse a zero-width instance
	if (WIDTH < 1) begin : g_bad_width
		$error("qrw_pin_sync: WIDTH must be at least 1");
	end

	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic s1_reg;
		logic s2_reg;
		logic s3_reg;
		logic out_reg;
		logic out_next;

		// first stage is read only by the second
		always_comb begin
			out_next = (s2_reg == s3_reg) ? s3_reg : out_reg;
		end

		always_ff @(posedge clk_sys or negedge nrst) begin
			if (!nrst) begin
				s1_reg  <= RESET_VAL[i];
				s2_reg  <= RESET_VAL[i];
				s3_reg  <= RESET_VAL[i];
				out_reg <= RESET_VAL[i];
			end else begin
				s1_reg  <= pinIn[i];
				s2_reg  <= s1_reg;
				s3_reg  <= s2_reg;
				out_reg <= out_next;
			end
		end

		assign pinStable[i] = out_reg;
	end
endmodule

/* rtl/qrw_quad_read.sv */
// device-side quad io read engine with continuous mode and burst wrap
// Function
// - quad read: address on four lines, four dummy clocks, then quad data
// - quad read opcode taken only while quad read enable bit set; continuous-mode frames skip the check
// - eight-bit continuous mode byte follows address, captured before dummies
// - only upper nibble of mode byte matters; lower nibble ignored
// - mode skip field 10: next frame starts directly with address
// - any other mode skip value: next frame starts with opcode
// - mode reset command clears mode byte, normal opcodes follow
// - stored wrap setting applies to every quad read
// - wrap keeps output within aligned 8/16/32/64-byte section of page
// - wrapped output starts at address, loops section until select rises
// - three-bit wrap setting: low bit disables, upper two select length
// - word read: two dummy clocks after mode byte before data
// - word read opcode taken only while quad read enable bit set; continuous-mode frames skip the check
// - word read with mode skip 10 repeats without opcode
// - wrap setting applies to word reads as to quad reads
// - length codes 00..11 give 8..64 bytes; disable bit default one
// - all-ones eight-clock sequence in continuous mode returns to opcode mode
module qrw_quad_read (
	input  wire logic              clk_sys,        // system clock, 10 MHz
	input  wire logic              nrst,           // async reset, active low
	input  wire qrw_pkg::qrw_pins_s pinsIn,        // select, serial clock, io inputs
	input  wire logic              quadEnable,     // quad read enable bit level
	input  wire logic              wrapLoad,       // pulse: store new wrap setting
	input  wire logic [2:0]        wrapBitsIn,     // wrap setting bits to store
	input  wire logic [7:0]        memRdData,      // byte at memAddr, one cycle late
	output logic      [3:0]        ioOut,          // io output levels
	output logic      [3:0]        ioOe,           // io drive enables, high drives
	output logic      [23:0]       memAddr,        // current read byte address
	output logic                   contModeActive, // next frame skips opcode
	output logic      [2:0]        wrapSetting     // stored wrap setting bits
);
	import qrw_pkg::*;

	qrw_pins_s  pinSync;
	logic       csHigh;
	logic       sclkRise;
	logic       sclkFall;
	logic       sclkPrev_reg;
	qrw_state_e state_reg, state_next;
	logic [2:0] cnt_reg, cnt_next;
	logic [7:0] opcode_reg, opcode_next;
	logic [7:0] modeByte_reg, modeByte_next;
	logic       contMode_reg, contMode_next;
	logic       isWord_reg, isWord_next;
	logic       hiPhase_reg, hiPhase_next;
	logic [23:0] addr_reg, addr_next;
	logic [23:0] memAddr_reg, memAddr_next;
	logic [3:0] ioOut_reg, ioOut_next;
	logic [3:0] ioOe_reg, ioOe_next;
	logic [2:0] wrapSetting_reg, wrapSetting_next;
	logic [7:0] opcodeFull;
	logic [7:0] modeFull;
	logic [2:0] dummyNeed;
	logic [23:0] wrapMask;
	logic [23:0] incAddr;
	logic [23:0] nextByteAddr;
	logic       advance;

	// pins come from the host's domain, so they are filtered first
	qrw_pin_sync #(
		.WIDTH     (6),
		.RESET_VAL (PINS_RESET)
	) u_sync (
		.clk_sys   (clk_sys),
		.nrst      (nrst),
		.pinIn     (pinsIn),
		.pinStable (pinSync)
	);
	// serial clock edges seen on the system clock
	assign csHigh   = pinSync.csN;
	assign sclkRise = pinSync.sclk & ~sclkPrev_reg;
	assign sclkFall = ~pinSync.sclk & sclkPrev_reg;
	// length field picks mask, codes 00..11
	always_comb begin
		unique case (wrapSetting_reg[2:1])
			2'h0: wrapMask = {18'h0, WRAP_MASK_8};
			2'h1: wrapMask = {18'h0, WRAP_MASK_16};
			2'h2: wrapMask = {18'h0, WRAP_MASK_32};
			2'h3: wrapMask = {18'h0, WRAP_MASK_64};
		endcase
	end
	// next byte address, wrapped or linear
	always_comb begin
		incAddr      = memAddr_reg + 24'h1;
		nextByteAddr = wrapSetting_reg[0] ? incAddr
		             : ((memAddr_reg & ~wrapMask) | (incAddr & wrapMask));
	end
	// dummy count depends on the command
	assign dummyNeed  = isWord_reg ? DUMMY_WORD_CLKS : DUMMY_QUAD_CLKS;
	assign opcodeFull = {opcode_reg[6:0], pinSync.io[0]};
	assign modeFull   = {modeByte_reg[3:0], pinSync.io};
	// wrap setting held until reloaded; used by both reads
	always_comb begin
		wrapSetting_next = wrapLoad ? wrapBitsIn : wrapSetting_reg;
	end
	// frame sequencer
	always_comb begin
		state_next    = state_reg;
		cnt_next      = cnt_reg;
		opcode_next   = opcode_reg;
		modeByte_next = modeByte_reg;
		contMode_next = contMode_reg;
		isWord_next   = isWord_reg;
		hiPhase_next  = hiPhase_reg;
		addr_next     = addr_reg;
		memAddr_next  = memAddr_reg;
		ioOut_next    = ioOut_reg;
		ioOe_next     = ioOe_reg;
		advance       = 1'b0;
		if (csHigh) begin
			// select high ends any command and frees the lines
			state_next   = ST_IDLE;
			cnt_next     = 3'h0;
			ioOe_next    = 4'h0;
			hiPhase_next = 1'b1;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					cnt_next = 3'h0;
					// continuous mode goes straight to the address
					state_next = contMode_reg ? ST_ADDR : ST_OPCODE;
				end
				ST_OPCODE: begin
					// opcode on one line, eight clocks
					if (sclkRise) begin
						opcode_next = opcodeFull;
						cnt_next    = cnt_reg + 3'h1;
						if (cnt_reg == OPCODE_LAST) begin
							cnt_next = 3'h0;
							// quad commands need the enable bit
							if (quadEnable && (opcodeFull == OPC_QUAD_READ ||
							                   opcodeFull == OPC_WORD_READ)) begin
								state_next  = ST_ADDR;
								isWord_next = (opcodeFull == OPC_WORD_READ);
							end else begin
								state_next = ST_IGNORE;
							end
							// mode reset clears the mode byte
							if (opcodeFull == OPC_MODE_RESET) begin
								modeByte_next = MODE_BYTE_RESET;
								contMode_next = 1'b0;
							end
						end
					end
				end
				ST_ADDR: begin
					if (sclkRise) begin
						addr_next = {addr_reg[19:0], pinSync.io};
						cnt_next  = cnt_reg + 3'h1;
						if (cnt_reg == ADDR_LAST) begin
							cnt_next     = 3'h0;
							state_next   = ST_MODE;
							// output begins at the given address
							memAddr_next = {addr_reg[19:0], pinSync.io};
						end
					end
				end
				ST_MODE: begin
					if (sclkRise) begin
						modeByte_next = modeFull;
						cnt_next      = cnt_reg + 3'h1;
						if (cnt_reg == MODE_LAST) begin
							cnt_next      = 3'h0;
							state_next    = ST_DUMMY;
							contMode_next = (modeFull[5:4] == MODE_SKIP_CONT);
						end
					end
				end
				ST_DUMMY: begin
					// count dummy rising edges, lines stay released
					if (sclkRise) begin
						cnt_next = cnt_reg + 3'h1;
						if (cnt_reg == dummyNeed - 3'h1) begin
							cnt_next     = 3'h0;
							state_next   = ST_DATA;
							hiPhase_next = 1'b1;
						end
					end
				end
				ST_DATA: begin
					// a byte per two clocks, driven on falling edges
					if (sclkFall) begin
						ioOe_next = 4'hf;
						if (hiPhase_reg) begin
							ioOut_next   = memRdData[7:4];
							hiPhase_next = 1'b0;
						end else begin
							ioOut_next   = memRdData[3:0];
							hiPhase_next = 1'b1;
							memAddr_next = nextByteAddr;
							advance      = 1'b1;
						end
					end
				end
				ST_IGNORE: begin
					// unsupported or refused command: wait for select high
					state_next = ST_IGNORE;
				end
			endcase
		end
	end
	// state registers; mode and wrap survive between frames
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sclkPrev_reg    <= 1'b0;
			state_reg       <= ST_IDLE;
			cnt_reg         <= 3'h0;
			opcode_reg      <= 8'h00;
			modeByte_reg    <= MODE_BYTE_RESET;
			contMode_reg    <= 1'b0;
			isWord_reg      <= 1'b0;
			hiPhase_reg     <= 1'b1;
			addr_reg        <= 24'h0;
			memAddr_reg     <= 24'h0;
			ioOut_reg       <= 4'h0;
			ioOe_reg        <= 4'h0;
			wrapSetting_reg <= WRAP_SETTING_RESET;
		end else begin
			sclkPrev_reg    <= pinSync.sclk;
			state_reg       <= state_next;
			cnt_reg         <= cnt_next;
			opcode_reg      <= opcode_next;
			modeByte_reg    <= modeByte_next;
			contMode_reg    <= contMode_next;
			isWord_reg      <= isWord_next;
			hiPhase_reg     <= hiPhase_next;
			addr_reg        <= addr_next;
			memAddr_reg     <= memAddr_next;
			ioOut_reg       <= ioOut_next;
			ioOe_reg        <= ioOe_next;
			wrapSetting_reg <= wrapSetting_next;
		end
	end
	assign ioOut          = ioOut_reg;
	assign ioOe           = ioOe_reg;
	assign memAddr        = memAddr_reg;
	assign contModeActive = contMode_reg;
	assign wrapSetting    = wrapSetting_reg;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	AST_QUAD_REFUSED: assert property (
		state_reg == ST_OPCODE && sclkRise && cnt_reg == OPCODE_LAST && !csHigh &&
		opcodeFull == OPC_QUAD_READ && !quadEnable |=> state_reg == ST_IGNORE)
		else $error("quad read accepted without enable");
	AST_WORD_REFUSED: assert property (
		state_reg == ST_OPCODE && sclkRise && cnt_reg == OPCODE_LAST && !csHigh &&
		opcodeFull == OPC_WORD_READ && !quadEnable |=> state_reg == ST_IGNORE)
		else $error("word read accepted without enable");
	AST_NO_DRIVE_BEFORE_DATA: assert property (
		state_reg inside {ST_ADDR, ST_MODE, ST_DUMMY} |-> ioOe_reg == 4'h0)
		else $error("io driven before data phase");
	AST_WORD_DUMMY: assert property (
		state_reg == ST_DUMMY && isWord_reg && sclkRise && !csHigh && cnt_reg == 3'h1
		|=> state_reg == ST_DATA)
		else $error("word read dummy count wrong");
	AST_MODE_SKIP: assert property (
		state_reg == ST_MODE && sclkRise && !csHigh && cnt_reg == MODE_LAST
		|=> contModeActive == (modeByte_reg[5:4] == MODE_SKIP_CONT))
		else $error("continuous mode not set from skip field");
	AST_MODE_RESET: assert property (
		state_reg == ST_OPCODE && sclkRise && !csHigh && cnt_reg == OPCODE_LAST &&
		opcodeFull == OPC_MODE_RESET |=> !contModeActive && modeByte_reg == MODE_BYTE_RESET)
		else $error("mode reset did not clear mode byte");
	AST_CONT_SKIPS_OPCODE: assert property (
		state_reg == ST_IDLE && !csHigh && contMode_reg |=> state_reg == ST_ADDR)
		else $error("continuous frame expected opcode");
	AST_WRAP_IN_PAGE: assert property (
		advance && !wrapSetting_reg[0]
		|=> memAddr[23:6] == $past(memAddr[23:6]) && memAddr != $past(memAddr))
		else $error("wrapped read left its section");
	AST_LINEAR_INC: assert property (
		advance && wrapSetting_reg[0] |=> memAddr == $past(memAddr) + 24'h1)
		else $error("linear read did not increment");
	AST_WRAP_LOAD: assert property (
		wrapLoad |=> ##1 wrapSetting == $past(wrapBitsIn, 2))
		else $error("wrap setting not stored");
	AST_RELEASE_ON_CS: assert property (
		csHigh |=> ioOe == 4'h0 && state_reg == ST_IDLE)
		else $error("io still driven after select high");

	COV_QUAD_DATA: cover property (state_reg == ST_DATA && !isWord_reg && advance);
	COV_WORD_DATA: cover property (state_reg == ST_DATA && isWord_reg && advance);
	COV_CONT_FRAME: cover property (state_reg == ST_IDLE && !csHigh && contMode_reg);
	COV_WRAP_TURN: cover property (advance && !wrapSetting_reg[0] &&
		(nextByteAddr & wrapMask) == 24'h0);
endmodule

/* dv/qrw_host_model.sv */
// host flash controller model driving the quad serial pins
module qrw_host_model (
	input  wire logic          clk_sys, // system clock
	input  wire logic [3:0]    ioOut,   // device io levels
	input  wire logic [3:0]    ioOe,    // device drive enables
	output qrw_pkg::qrw_pins_s pins     // select, clock, resolved io
);
	timeunit 1ns;
	timeprecision 1ns;
	import qrw_pkg::*;
	logic       csN = 1'b1;
	logic       sclk = 1'b0;
	logic [3:0] hostIo = 4'h0;
	logic       hostOe = 1'b1;
	logic       inFrame = 1'b0;
	logic       sawOe = 1'b0;
	logic [3:0] ioWire;
	logic [7:0] rd[$];

	// wire level: device where its enables are set, host on the other lines
	assign ioWire = (ioOe & ioOut) | (~ioOe & hostIo);
	assign pins = {csN, sclk, ioWire};

	// note any device drive inside a frame
	always @(posedge clk_sys) begin
		if (inFrame && ioOe !== 4'h0)
			sawOe <= 1'b1;
	end

	task automatic wt(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	// one serial clock; released lines toggle so stale levels never look valid
	task automatic pulse(input logic [3:0] v);
		hostIo = hostOe ? v : ~hostIo;
		sclk = 1'b0;
		wt(4);
		sclk = 1'b1;
		wt(4);
	endtask

	task automatic frame(input logic [7:0] opc, input bit useOpc, input logic [23:0] addr,
			input logic [7:0] mode, input int nDummy, input int nByte);
		logic [3:0] hiNib;
		rd.delete();
		sawOe = 1'b0;
		inFrame = 1'b1;
		hostOe = 1'b1;
		wt(1);
		csN = 1'b0;
		wt(4);
		if (useOpc)
			for (int i = 7; i >= 0; i--) pulse({3'h0, opc[i]});
		for (int i = 5; i >= 0; i--) pulse(addr[i*4+:4]);
		pulse(mode[7:4]);
		pulse(mode[3:0]);
		hostOe = 1'b0;
		repeat (nDummy) pulse(4'h0);
		repeat (nByte) begin
			pulse(4'h0);
			hiNib = ioWire;
			pulse(4'h0);
			rd.push_back({hiNib, ioWire});
		end
		// select rises before clock drops, so no stray fall inside the frame
		csN = 1'b1;
		wt(2);
		sclk = 1'b0;
		wt(8);
		inFrame = 1'b0;
		hostOe = 1'b1;
	endtask
endmodule

/* dv/qrw_quad_read_test.sv */
// self-checking bench for the quad read engine
module qrw_quad_read_test;
	timeunit 1ns;
	timeprecision 1ns;
	import qrw_pkg::*;
	logic       clk_sys = 1'b0;
	logic       nrst = 1'b0;
	logic       quadEnable = 1'b0;
	logic       wrapLoad = 1'b0;
	logic [2:0] wrapBitsIn = 3'h1;
	logic [7:0] memRdData = 8'h00;
	qrw_pins_s  pins;
	logic [3:0] ioOut, ioOe;
	logic [23:0] memAddr;
	logic       contModeActive;
	logic [2:0] wrapSetting;
	int         nMismatch = 0;
	int         testsRun = 0;
	int         cycles = 0;

	// 10 MHz clock
	initial forever #50 clk_sys = ~clk_sys;

	qrw_quad_read DUT (.clk_sys(clk_sys), .nrst(nrst), .pinsIn(pins), .quadEnable(quadEnable),
		.wrapLoad(wrapLoad), .wrapBitsIn(wrapBitsIn), .memRdData(memRdData), .ioOut(ioOut),
		.ioOe(ioOe), .memAddr(memAddr), .contModeActive(contModeActive),
		.wrapSetting(wrapSetting));
	qrw_host_model host (.clk_sys(clk_sys), .ioOut(ioOut), .ioOe(ioOe), .pins(pins));

	function automatic logic [7:0] memByte(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ 8'ha5;
	endfunction

	// memory answers off the sampling edge
	always @(negedge clk_sys) memRdData <= memByte(memAddr);

	// hang guard, far above the few thousand cycles needed
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 60000) begin
			nMismatch++;
			finish_test();
		end
	end

	task automatic finish_test;
		$display("mismatches %0d, checks %0d", nMismatch, testsRun);
		if (nMismatch == 0 && testsRun > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic cmpByte(input logic [7:0] got, input logic [7:0] exp, input string what);
		testsRun++;
		if (got !== exp) begin
			nMismatch++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic cmpBit(input logic got, input logic exp, input string what);
		testsRun++;
		if (got !== exp) begin
			nMismatch++;
			$display("wrong value at %0t: %s got %b exp %b", $time, what, got, exp);
		end
	endtask

	// expected bytes follow the address, folded into the section when wrapping
	task automatic checkRead(input logic [23:0] addr, input logic [5:0] mask, input bit wrap,
			input int n);
		logic [5:0]  off;
		logic [23:0] a;
		cmpByte(8'(host.rd.size()), 8'(n), "byte count");
		for (int i = 0; i < n; i++) begin
			off = addr[5:0] + 6'(i);
			a = wrap ? {addr[23:6], (addr[5:0] & ~mask) | (off & mask)} : addr + 24'(i);
			cmpByte(host.rd[i], memByte(a), "read byte");
		end
	endtask

	task automatic loadWrap(input logic [2:0] w);
		@(negedge clk_sys);
		wrapBitsIn = w;
		wrapLoad = 1'b1;
		@(negedge clk_sys);
		wrapLoad = 1'b0;
		@(negedge clk_sys);
		cmpByte({5'h0, wrapSetting}, {5'h0, w}, "wrap setting");
	endtask

	task automatic testReset;
		cmpByte({5'h0, wrapSetting}, 8'h01, "wrap default");
		cmpBit(contModeActive, 1'b0, "cont after reset");
		cmpByte({4'h0, ioOe}, 8'h00, "oe after reset");
	endtask

	// commands with the enable bit clear are ignored
	task automatic testRefused;
		host.frame(OPC_QUAD_READ, 1, 24'h000010, 8'h20, 4, 2);
		cmpBit(host.sawOe, 1'b0, "quad read refused");
		host.frame(OPC_WORD_READ, 1, 24'h000010, 8'h20, 2, 2);
		cmpBit(host.sawOe, 1'b0, "word read refused");
		cmpBit(contModeActive, 1'b0, "no cont when refused");
		@(negedge clk_sys);
		quadEnable = 1'b1;
	endtask

	// plain read across a page edge
	task automatic testPlain;
		host.frame(OPC_QUAD_READ, 1, 24'h0000fe, 8'h1f, 4, 4);
		checkRead(24'h0000fe, 6'h00, 0, 4);
		cmpBit(contModeActive, 1'b0, "skip 01");
		cmpByte({4'h0, ioOe}, 8'h00, "oe after select");
	endtask

	task automatic testCont;
		host.frame(OPC_WORD_READ, 1, 24'h000120, 8'h2f, 2, 3);
		checkRead(24'h000120, 6'h00, 0, 3);
		cmpBit(contModeActive, 1'b1, "skip 10 low nibble set");
		host.frame(OPC_WORD_READ, 0, 24'h000142, 8'ha0, 2, 2);
		checkRead(24'h000142, 6'h00, 0, 2);
		host.frame(OPC_WORD_READ, 0, 24'h000144, 8'hc3, 2, 2);
		checkRead(24'h000144, 6'h00, 0, 2);
		cmpBit(contModeActive, 1'b0, "skip 00 leaves");
		host.frame(OPC_QUAD_READ, 1, 24'h000150, 8'h2a, 4, 2);
		checkRead(24'h000150, 6'h00, 0, 2);
		cmpBit(contModeActive, 1'b1, "quad skip 10");
		host.frame(OPC_QUAD_READ, 0, 24'h000160, 8'h20, 4, 2);
		checkRead(24'h000160, 6'h00, 0, 2);
		host.frame(8'h00, 0, 24'hffffff, 8'hff, 0, 0);
		cmpBit(contModeActive, 1'b0, "all ones exit");
		// opcode-led mode reset: the rest of the frame is ignored
		host.frame(OPC_MODE_RESET, 1, 24'h000000, 8'h20, 0, 0);
		cmpBit(host.sawOe, 1'b0, "mode reset not a read");
		cmpBit(contModeActive, 1'b0, "mode reset clears");
		host.frame(OPC_QUAD_READ, 1, 24'h000200, 8'h00, 4, 2);
		checkRead(24'h000200, 6'h00, 0, 2);
	endtask

	// each section length, word read on the last one, then wrap off
	task automatic testWrap;
		logic [5:0]  mask;
		logic [23:0] start;
		for (int len = 0; len < 4; len++) begin
			mask = 6'((8 << len) - 1);
			start = {18'h00010, mask & 6'h3e};
			loadWrap({2'(len), 1'b0});
			if (len == 3)
				host.frame(OPC_WORD_READ, 1, start, 8'h00, 2, int'(mask) + 3);
			else
				host.frame(OPC_QUAD_READ, 1, start, 8'h00, 4, int'(mask) + 3);
			checkRead(start, mask, 1, int'(mask) + 3);
		end
		loadWrap(3'h7);
		host.frame(OPC_QUAD_READ, 1, 24'h0004fe, 8'h00, 4, 3);
		checkRead(24'h0004fe, 6'h00, 0, 3);
		loadWrap(3'h1);
	endtask

	// main sequence
	initial begin
		repeat (16) @(negedge clk_sys);
		nrst = 1'b1;
		repeat (6) @(negedge clk_sys);
		testReset();
		testRefused();
		testPlain();
		testCont();
		testWrap();
		finish_test();
	end
endmodule
